/* src/sft_consts.svh */
// register addresses, field positions, reset values and counts for the spi queue block
// assumes an 8-bit special-register port with separate read and write strobes
`ifndef SFT_CONSTS_SVH
`define SFT_CONSTS_SVH

`define SFT_ADDR_CLK_RATE   8'hA2
`define SFT_ADDR_FILL_CNT   8'hF7
`define SFT_ADDR_DATA       8'hA3
`define SFT_ADDR_QCTL0      8'h9A
`define SFT_ADDR_QCTL1      8'h9B
`define SFT_ADDR_STATUS     8'h9C

`define SFT_DEPTH           4
`define SFT_LVL_W           3
`define SFT_TO_SHIFT        5

// queue control 0
`define SFT_Q0_RX_TH        0
`define SFT_Q0_RX_FLUSH     2
`define SFT_Q0_RX_REQ_EN    3
`define SFT_Q0_TX_TH        4
`define SFT_Q0_TX_FLUSH     6
`define SFT_Q0_TX_REQ_EN    7
// queue control 1
`define SFT_Q1_TO_EN        0
`define SFT_Q1_RX_EN        1
`define SFT_Q1_IDLE_LVL     2
`define SFT_Q1_STALL        3
`define SFT_Q1_DONE_EN      4
// status
`define SFT_ST_RX_EMPTY     0
`define SFT_ST_TX_NFULL     1
`define SFT_ST_WCOL         2
`define SFT_ST_DONE         3
`define SFT_ST_RX_REQ       4
`define SFT_ST_TX_REQ       5
`define SFT_ST_TIMEOUT      6

`define SFT_RST_RATE        8'h00
`define SFT_RST_QCTL0       8'h00
`define SFT_RST_QCTL1       8'h02

`endif

/* src/sft_fifo.sv */
// byte queue with flush, level and full/empty status
// a push while full and a pop while empty are both ignored
`timescale 1ns/10ps
module sft_fifo #(
   parameter int DEPTH = 4,
   parameter int LW    = 3
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // control
   input  wire logic          push,
   input  wire logic [7:0]    din,
   input  wire logic          pop,
   input  wire logic          flush,
   // status
   output logic [7:0]         dout,
   output logic [LW-1:0]      level,
   output logic               full,
   output logic               empty
);
   localparam int AW = $clog2(DEPTH);

   logic [7:0]    mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [LW-1:0] cnt_q;

   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      nxt = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   always_ff @(posedge clk) begin
      if (push && !full) begin
         mem_q[wp_q] <= din;
      end
   end

   // flush wins over push and pop in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push && !full) begin
            wp_q <= nxt(wp_q);
         end
         if (pop && !empty) begin
            rp_q <= nxt(rp_q);
         end
         cnt_q <= cnt_q + LW'(push && !full) - LW'(pop && !empty);
      end
   end

   assign dout  = mem_q[rp_q];
   assign level = cnt_q;
   assign full  = (cnt_q == LW'(DEPTH));
   assign empty = (cnt_q == '0);
endmodule

/* src/sft_link.sv */
// slave-side byte shifter on the serial clock; talks to the system side by toggles
// assumes mosi is stable at the rising serial clock edge and data moves msb first
`timescale 1ns/10ps
module sft_link
   import sft_pkg::*;
(
   // link clock and reset
   input  wire logic          sck,
   input  wire logic          rst,
   // serial pins
   input  wire logic          mosi,
   output logic               miso,
   output logic               miso_oe,
   // from system side
   input  wire sft_link_ctl_t ctl,
   input  wire logic          tx_req,
   input  wire logic [7:0]    tx_data,
   // to system side
   output logic               tx_ack,
   output logic               byte_tgl,
   output logic               edge_tgl,
   output sft_rx_t            rx
);
   logic [3:0]    s1_q;
   logic [3:0]    s2_q;
   logic [3:0]    s3_q;
   logic [3:0]    lvl_q;
   sft_link_ctl_t ctl_s;
   logic          req_s;
   logic [2:0]    bit_q;
   logic [7:0]    sh_q;
   logic          hold_q;
   logic          hold_lvl_q;
   logic [7:0]    in_byte;

   // a level only moves once the second and third stage agree
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         // stages start at the reset level so no false change follows reset
         s1_q  <= 4'h2;
         s2_q  <= 4'h2;
         s3_q  <= 4'h2;
         lvl_q <= 4'h2;
      end else begin
         s1_q  <= {ctl, tx_req};
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= (s3_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
      end
   end
   assign ctl_s   = sft_link_ctl_t'(lvl_q[3:1]);
   assign req_s   = lvl_q[0];
   assign in_byte = {sh_q[6:0], mosi};

   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         bit_q    <= '0;
         sh_q     <= '0;
         hold_q   <= 1'b0;
         hold_lvl_q <= 1'b0;
         tx_ack   <= 1'b0;
         byte_tgl <= 1'b0;
         edge_tgl <= 1'b0;
         rx       <= '0;
      end else begin
         edge_tgl <= ~edge_tgl;
         bit_q    <= bit_q + 3'h1;
         if (bit_q == 3'h7) begin
            rx       <= '{keep: ctl_s.rx_keep, data: in_byte};
            byte_tgl <= ~byte_tgl;
            if (ctl_s.stall) begin
               hold_q <= 1'b1;
               // level fixed for the whole byte, even if software moves it
               hold_lvl_q <= ctl_s.idle_level;
               sh_q   <= in_byte;
            end else if (req_s != tx_ack) begin
               hold_q <= 1'b0;
               sh_q   <= tx_data;
               tx_ack <= ~tx_ack;
            end else begin
               // nothing queued: the received byte goes back out
               hold_q <= 1'b0;
               sh_q   <= in_byte;
            end
         end else begin
            sh_q <= in_byte;
         end
      end
   end

   assign miso    = hold_q ? hold_lvl_q : sh_q[7];
   assign miso_oe = 1'b1;
endmodule

/* src/sft_pkg.sv */
// types shared by the spi queue block and its link-side shifter
// assumes nothing beyond a systemverilog compiler
package sft_pkg;

   typedef struct packed {
      logic stall;
      logic idle_level;
      logic rx_keep;
   } sft_link_ctl_t;

   typedef struct packed {
      logic       keep;
      logic [7:0] data;
   } sft_rx_t;

endpackage

/* src/sft_top.sv */
// spi transmit and receive queues with thresholds, request flags and slave receive timeout
// assumes an 8-bit register port with one-cycle read/write strobes on clk, and an
// external master clocking the link on sck; the shifter runs on sck
//
// What this block does
// - separate four-byte transmit and receive queues, used in the slave role.
// - tx_not_full reads one while the transmit queue has a free entry.
// - a data write while the queue is full is dropped and flags a collision.
// - rx_empty reads zero while the receive queue holds a byte, else one.
// - reading an empty receive queue returns the last received byte.
// - writing one to a flush bit resets that queue's pointers.
// - stall sampled at byte start; when set, the holding word is not sent, output idles.
// - receive enable sampled at byte end; when clear, the byte is discarded.
// - stall and receive enable change anytime; a loaded byte survives a flush.
// - a count register shows transmit and receive queue levels separately.
// - tx_request_flag is one while tx_level is at or below tx_threshold.
// - rx_request_flag is one while rx_level is above rx_threshold.
// - each request flag interrupts only with its own enable set.
// - an unfed slave transmit queue echoes received bytes back out.
// - receive timeout works only while rx_timeout_enable is one.
// - timeout length is the clock-rate value times 32 system clocks.
// - the timeout counts only with data queued and rx_request_flag clear.
// - reload on queue read, request flag rising, or each rising serial clock edge.
// - an expired timeout raises the interrupt so software drains the queue.
`timescale 1ns/10ps
`include "sft_consts.svh"
module sft_top
   import sft_pkg::*;
#(
   parameter int DEPTH = `SFT_DEPTH
) (
   // clocks and reset
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       sck,
   // register port
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic [7:0]      sfr_rdata,
   // serial pins
   input  wire logic       mosi,
   output logic            miso,
   output logic            miso_oe,
   // interrupt
   output logic            spi_irq
);
   localparam int LW = `SFT_LVL_W;
   localparam int TW = 8 + `SFT_TO_SHIFT;

   // register state
   logic [7:0]    rate_q;
   logic [7:0]    qctl0_q;
   logic [7:0]    qctl1_q;
   logic          wcol_q;
   logic          done_q;
   logic          tmo_q;
   logic [7:0]    last_rx_q;

   // queue wiring
   logic          tx_push;
   logic          tx_pop;
   logic          tx_flush;
   logic [7:0]    tx_head;
   logic [LW-1:0] tx_level;
   logic          tx_full;
   logic          tx_empty;
   logic          rx_push;
   logic          rx_pop;
   logic          rx_flush;
   logic [7:0]    rx_head;
   logic [LW-1:0] rx_level;
   logic          rx_full;
   logic          rx_empty;

   // crossing state
   logic          tx_req_q;
   logic [7:0]    tx_word_q;
   logic          tx_ack_l;
   logic          byte_tgl_l;
   logic          edge_tgl_l;
   sft_rx_t       rx_l;
   logic [2:0]    cs1_q;
   logic [2:0]    cs2_q;
   logic [2:0]    cs3_q;
   logic [2:0]    seen_q;
   logic [2:0]    agree;
   logic          byte_ev;
   logic          edge_ev;
   logic          ack_lvl;
   sft_link_ctl_t link_ctl_q;

   // decoded controls
   logic [1:0]    rx_threshold;
   logic [1:0]    tx_threshold;
   logic          rx_request_irq_en;
   logic          tx_request_irq_en;
   logic          rx_timeout_enable;
   logic          rx_queue_enable;
   logic          tx_idle_level;
   logic          tx_stall;
   logic          transfer_done_irq_en;
   logic          tx_not_full;
   logic          tx_request_flag;
   logic          rx_request_flag;
   logic          rx_req_prev_q;

   // timeout
   logic [TW-1:0] tmo_cnt_q;
   logic          tmo_reload;
   logic          tmo_run;
   logic          tmo_expire;

   // register accesses
   logic          wr_data;
   logic          rd_data;
   logic          wr_qctl0;
   logic          wr_status;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
      hit = (a == ref_a);
   endfunction

   assign wr_data   = sfr_wr && hit(sfr_addr, `SFT_ADDR_DATA);
   assign rd_data   = sfr_rd && hit(sfr_addr, `SFT_ADDR_DATA);
   assign wr_qctl0  = sfr_wr && hit(sfr_addr, `SFT_ADDR_QCTL0);
   assign wr_status = sfr_wr && hit(sfr_addr, `SFT_ADDR_STATUS);

   assign rx_threshold         = qctl0_q[`SFT_Q0_RX_TH +: 2];
   assign tx_threshold         = qctl0_q[`SFT_Q0_TX_TH +: 2];
   assign rx_request_irq_en    = qctl0_q[`SFT_Q0_RX_REQ_EN];
   assign tx_request_irq_en    = qctl0_q[`SFT_Q0_TX_REQ_EN];
   assign rx_timeout_enable    = qctl1_q[`SFT_Q1_TO_EN];
   assign rx_queue_enable      = qctl1_q[`SFT_Q1_RX_EN];
   assign tx_idle_level        = qctl1_q[`SFT_Q1_IDLE_LVL];
   assign tx_stall             = qctl1_q[`SFT_Q1_STALL];
   assign transfer_done_irq_en = qctl1_q[`SFT_Q1_DONE_EN];

   // control registers; flush bits are strobes and read back as zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rate_q  <= `SFT_RST_RATE;
         qctl0_q <= `SFT_RST_QCTL0;
         qctl1_q <= `SFT_RST_QCTL1;
      end else if (sfr_wr) begin
         if (hit(sfr_addr, `SFT_ADDR_CLK_RATE)) begin
            rate_q <= sfr_wdata;
         end
         if (wr_qctl0) begin
            qctl0_q <= sfr_wdata & ~((8'h01 << `SFT_Q0_RX_FLUSH) | (8'h01 << `SFT_Q0_TX_FLUSH));
         end
         if (hit(sfr_addr, `SFT_ADDR_QCTL1)) begin
            qctl1_q <= sfr_wdata & 8'h1F;
         end
      end
   end

   assign tx_flush = wr_qctl0 && sfr_wdata[`SFT_Q0_TX_FLUSH];
   assign rx_flush = wr_qctl0 && sfr_wdata[`SFT_Q0_RX_FLUSH];

   // queues
   assign tx_not_full = !tx_full;
   assign tx_push     = wr_data && tx_not_full;
   assign rx_pop      = rd_data && !rx_empty;
   assign rx_push     = byte_ev && rx_l.keep;

   sft_fifo #(.DEPTH(DEPTH), .LW(LW)) u_tx_q (
      .clk   (clk),
      .rst   (rst),
      .push  (tx_push),
      .din   (sfr_wdata),
      .pop   (tx_pop),
      .flush (tx_flush),
      .dout  (tx_head),
      .level (tx_level),
      .full  (tx_full),
      .empty (tx_empty)
   );

   sft_fifo #(.DEPTH(DEPTH), .LW(LW)) u_rx_q (
      .clk   (clk),
      .rst   (rst),
      .push  (rx_push),
      .din   (rx_l.data),
      .pop   (rx_pop),
      .flush (rx_flush),
      .dout  (rx_head),
      .level (rx_level),
      .full  (rx_full),
      .empty (rx_empty)
   );

   // link toggles: three stages, an event counts once stages two and three agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cs1_q  <= '0;
         cs2_q  <= '0;
         cs3_q  <= '0;
         seen_q <= '0;
      end else begin
         cs1_q  <= {edge_tgl_l, tx_ack_l, byte_tgl_l};
         cs2_q  <= cs1_q;
         cs3_q  <= cs2_q;
         seen_q <= (cs3_q & agree) | (seen_q & ~agree);
      end
   end
   assign agree   = ~(cs2_q ^ cs3_q);
   assign byte_ev = agree[0] && (cs3_q[0] != seen_q[0]);
   assign edge_ev = agree[2] && (cs3_q[2] != seen_q[2]);
   assign ack_lvl = seen_q[1];

   // one byte waits in the holding word; flushing the queue leaves it to finish
   assign tx_pop = (tx_req_q == ack_lvl) && !tx_empty && !tx_flush;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_req_q  <= 1'b0;
         tx_word_q <= '0;
      end else if (tx_pop) begin
         tx_word_q <= tx_head;
         tx_req_q  <= ~tx_req_q;
      end
   end

   // stall and receive enable go over as levels and may change at any time
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         link_ctl_q <= '0;
      end else begin
         link_ctl_q <= '{stall: tx_stall, idle_level: tx_idle_level,
                         rx_keep: rx_queue_enable};
      end
   end

   sft_link u_link (
      .sck      (sck),
      .rst      (rst),
      .mosi     (mosi),
      .miso     (miso),
      .miso_oe  (miso_oe),
      .ctl      (link_ctl_q),
      .tx_req   (tx_req_q),
      .tx_data  (tx_word_q),
      .tx_ack   (tx_ack_l),
      .byte_tgl (byte_tgl_l),
      .edge_tgl (edge_tgl_l),
      .rx       (rx_l)
   );

   // last byte off the wire, kept even when the receive queue is off
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last_rx_q <= '0;
      end else if (byte_ev) begin
         last_rx_q <= rx_l.data;
      end
   end

   // request flags follow the levels combinationally
   assign tx_request_flag = (tx_level <= LW'(tx_threshold));
   assign rx_request_flag = (rx_level > LW'(rx_threshold));

   // sticky flags: a new event in the clearing cycle wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wcol_q <= 1'b0;
         done_q <= 1'b0;
         tmo_q  <= 1'b0;
      end else begin
         wcol_q <= (wr_data && tx_full) || (wcol_q && !(wr_status && !sfr_wdata[`SFT_ST_WCOL]));
         done_q <= byte_ev || (done_q && !(wr_status && !sfr_wdata[`SFT_ST_DONE]));
         tmo_q  <= tmo_expire || (tmo_q && !(wr_status && !sfr_wdata[`SFT_ST_TIMEOUT]));
      end
   end

   // receive timeout
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_req_prev_q <= 1'b0;
      end else begin
         rx_req_prev_q <= rx_request_flag;
      end
   end
   assign tmo_reload = rd_data || (rx_request_flag && !rx_req_prev_q) || edge_ev;
   assign tmo_run    = rx_timeout_enable && !rx_empty && !rx_request_flag;
   assign tmo_expire = tmo_run && !tmo_reload && (tmo_cnt_q == TW'(1));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tmo_cnt_q <= '0;
      end else if (tmo_reload || !tmo_run) begin
         tmo_cnt_q <= {rate_q, `SFT_TO_SHIFT'(0)};
      end else if (tmo_cnt_q != '0) begin
         tmo_cnt_q <= tmo_cnt_q - TW'(1);
      end
   end

   // interrupt
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         spi_irq <= 1'b0;
      end else begin
         spi_irq <= (done_q && transfer_done_irq_en) ||
                    (tx_request_flag && tx_request_irq_en) ||
                    (rx_request_flag && rx_request_irq_en) ||
                    (tmo_q && rx_timeout_enable);
      end
   end

   // read data, one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sfr_rdata <= '0;
      end else if (sfr_rd) begin
         case (sfr_addr)
            `SFT_ADDR_DATA: begin
               sfr_rdata <= rx_empty ? last_rx_q : rx_head;
            end
            `SFT_ADDR_CLK_RATE: begin
               sfr_rdata <= rate_q;
            end
            `SFT_ADDR_FILL_CNT: begin
               sfr_rdata <= {1'b0, tx_level, 1'b0, rx_level};
            end
            `SFT_ADDR_QCTL0: begin
               sfr_rdata <= qctl0_q;
            end
            `SFT_ADDR_QCTL1: begin
               sfr_rdata <= qctl1_q;
            end
            `SFT_ADDR_STATUS: begin
               sfr_rdata <= {1'b0, tmo_q, tx_request_flag, rx_request_flag, done_q,
                             wcol_q, tx_not_full, rx_empty};
            end
            default: begin
               sfr_rdata <= '0;
            end
         endcase
      end
   end
endmodule

/* test/sft_spi_master.sv */
// serial master model for the slave link of the spi queue block
// assumes mode 0: data set while the clock is low, both ends sample on the rise
`timescale 1ns/10ps
module sft_spi_master (
   // link pins
   output logic      sck,
   output logic      mosi,
   input  wire logic miso
);
   // one edge while reset is held, then the clock stands still
   initial begin
      sck  = 1'b0;
      mosi = 1'b0;
      #5.3 sck = 1'b1;
      #8 sck = 1'b0;
   end

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      #1.3;
      for (int i = 7; i >= 0; i--) begin
         mosi = tx[i];
         #32;
         rx[i] = miso;
         sck = 1'b1;
         #32;
         sck = 1'b0;
      end
      // released line shows no stale bit
      mosi = ~tx[0];
   endtask
endmodule

/* test/sft_top_asserts.sv */
// concurrent checks on the ports of the spi queue block
// assumes read data one clk after the strobe; shadows follow bus writes only
`timescale 1ns/10ps
`include "sft_consts.svh"
module sft_top_asserts #(
   parameter int DEPTH = 4
) (
   // clocks and reset
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       sck,
   // register port
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // serial pins
   input wire logic       mosi,
   input wire logic       miso,
   input wire logic       miso_oe,
   // interrupt
   input wire logic       spi_irq
);
   logic [7:0] q0_q;
   logic [7:0] q1_q;
   logic [7:0] rate_q;
   wire logic  en_any;
   wire logic  mapped;

   assign en_any = q0_q[7] | q0_q[3] | q1_q[4] | q1_q[0];
   assign mapped = sfr_addr inside {`SFT_ADDR_CLK_RATE, `SFT_ADDR_FILL_CNT, `SFT_ADDR_DATA,
                                    `SFT_ADDR_QCTL0, `SFT_ADDR_QCTL1, `SFT_ADDR_STATUS};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q0_q   <= `SFT_RST_QCTL0;
         q1_q   <= `SFT_RST_QCTL1;
         rate_q <= `SFT_RST_RATE;
      end else if (sfr_wr) begin
         if (sfr_addr == `SFT_ADDR_QCTL0) q0_q <= sfr_wdata;
         if (sfr_addr == `SFT_ADDR_QCTL1) q1_q <= sfr_wdata;
         if (sfr_addr == `SFT_ADDR_CLK_RATE) rate_q <= sfr_wdata;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence seq_st_rd;
      sfr_rd && sfr_addr == `SFT_ADDR_STATUS;
   endsequence
   sequence seq_fill_rd;
      sfr_rd && sfr_addr == `SFT_ADDR_FILL_CNT;
   endsequence
   sequence seq_flush_wr;
      sfr_wr && sfr_addr == `SFT_ADDR_QCTL0 && sfr_wdata[`SFT_Q0_TX_FLUSH];
   endsequence

   a_oe_driven: assert property (miso_oe)
      else $error("miso enable low");
   a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (sfr_rd && !mapped |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_fill_bounds: assert property (seq_fill_rd |=> sfr_rdata[6:4] <= DEPTH
      && sfr_rdata[2:0] <= DEPTH && !sfr_rdata[7] && !sfr_rdata[3])
      else $error("fill count out of range");
   a_empty_noreq: assert property (seq_st_rd |=> !(sfr_rdata[0] && sfr_rdata[4]))
      else $error("receive request while empty");
   a_full_notxreq: assert property (seq_st_rd |=> sfr_rdata[1] || !sfr_rdata[5])
      else $error("transmit request while full");
   a_flush_empties: assert property (seq_flush_wr ##1 !sfr_wr ##1 seq_fill_rd
      |=> sfr_rdata[6:4] == 3'h0)
      else $error("transmit level not zero after flush");
   a_ctl_readback: assert property (sfr_rd && sfr_addr == `SFT_ADDR_QCTL0
      |=> sfr_rdata == ($past(q0_q) & 8'hBB))
      else $error("queue control readback wrong");
   a_rate_readback: assert property (sfr_rd && sfr_addr == `SFT_ADDR_CLK_RATE
      |=> sfr_rdata == $past(rate_q))
      else $error("clock rate readback wrong");
   a_irq_quiet: assert property (!en_any && !$past(en_any) |-> !spi_irq)
      else $error("interrupt with all sources disabled");
endmodule

bind sft_top sft_top_asserts #(.DEPTH(DEPTH)) u_sft_top_asserts (
   .clk(clk), .rst(rst), .sck(sck), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .mosi(mosi), .miso(miso),
   .miso_oe(miso_oe), .spi_irq(spi_irq));

/* test/sft_top_test.sv */
// self-checking bench for the spi queue block with a serial master model
// assumes the block's register port on clk and a 64 ns link clock from the model
`timescale 1ns/10ps
`include "sft_consts.svh"
module sft_top_test;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic       sfr_wr = 1'b0;
   logic       sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic       sck, mosi, miso, miso_oe, spi_irq;
   int         miscompares = 0;
   int         cmp_count = 0;
   int         cyc = 0;

   always #2 clk = ~clk;

   sft_top #(.DEPTH(4)) u_sft_top (
      .clk(clk), .rst(rst), .sck(sck), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .mosi(mosi),
      .miso(miso), .miso_oe(miso_oe), .spi_irq(spi_irq));
   sft_spi_master u_sft_spi_master (.sck(sck), .mosi(mosi), .miso(miso));

   task automatic report_and_stop;
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         report_and_stop;
      end
   end

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask

   task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      chk(name, exp, sfr_rdata);
   endtask

   // queue transfers lag the link by a few synchroniser stages
   task automatic frame(input logic [7:0] tx, input logic [7:0] exp, input bit check);
      logic [7:0] r;
      u_sft_spi_master.xfer(tx, r);
      repeat (8) @(negedge clk);
      if (check) chk("miso byte", exp, r);
   endtask

   task automatic irq_after(input int n, input logic exp);
      repeat (n) @(negedge clk);
      chk("irq", {7'h00, exp}, {7'h00, spi_irq});
   endtask

   task automatic t_reset_vals;
      rd("rate", `SFT_ADDR_CLK_RATE, 8'h00);
      rd("ctl0", `SFT_ADDR_QCTL0, 8'h00);
      rd("ctl1", `SFT_ADDR_QCTL1, 8'h02);
      rd("fill", `SFT_ADDR_FILL_CNT, 8'h00);
      rd("status", `SFT_ADDR_STATUS, 8'h23);
      wr(8'h55, 8'hFF);
      rd("unmapped", 8'h55, 8'h00);
   endtask

   // first byte sits in the holding word, four more fill the queue
   task automatic t_fill_collide;
      for (int i = 0; i < 6; i++) wr(`SFT_ADDR_DATA, 8'hA1 + 8'(i));
      rd("fill", `SFT_ADDR_FILL_CNT, 8'h40);
      rd("status", `SFT_ADDR_STATUS, 8'h05);
      wr(`SFT_ADDR_QCTL0, 8'h70);
      rd("fill", `SFT_ADDR_FILL_CNT, 8'h00);
      rd("ctl0", `SFT_ADDR_QCTL0, 8'h30);
      for (int i = 0; i < 3; i++) wr(`SFT_ADDR_DATA, 8'h10);
      rd("status", `SFT_ADDR_STATUS, 8'h27);
      wr(`SFT_ADDR_QCTL0, 8'h72);
      wr(`SFT_ADDR_STATUS, 8'h00);
      rd("status", `SFT_ADDR_STATUS, 8'h23);
   endtask

   task automatic t_link;
      frame(8'h3C, 8'h00, 1'b0);
      frame(8'hC3, 8'hA1, 1'b1);
      frame(8'h5A, 8'hC3, 1'b1);
      rd("fill", `SFT_ADDR_FILL_CNT, 8'h03);
      rd("status", `SFT_ADDR_STATUS, 8'h3A);
      rd("data", `SFT_ADDR_DATA, 8'h3C);
      rd("status", `SFT_ADDR_STATUS, 8'h2A);
      rd("data", `SFT_ADDR_DATA, 8'hC3);
      rd("data", `SFT_ADDR_DATA, 8'h5A);
      rd("data", `SFT_ADDR_DATA, 8'h5A);
      rd("status", `SFT_ADDR_STATUS, 8'h2B);
   endtask

   task automatic t_stall_discard;
      wr(`SFT_ADDR_QCTL1, 8'h0C);
      wr(`SFT_ADDR_DATA, 8'h96);
      frame(8'h11, 8'h00, 1'b0);
      frame(8'h22, 8'hFF, 1'b1);
      rd("fill", `SFT_ADDR_FILL_CNT, 8'h00);
      wr(`SFT_ADDR_QCTL1, 8'h02);
      frame(8'h33, 8'hFF, 1'b1);
      frame(8'h44, 8'h96, 1'b1);
      rd("fill", `SFT_ADDR_FILL_CNT, 8'h02);
      rd("data", `SFT_ADDR_DATA, 8'h33);
   endtask

   // done interrupt stays disabled while request sources are in use
   task automatic t_timeout;
      wr(`SFT_ADDR_CLK_RATE, 8'h02);
      // byte queued, request clear, but timeout still disabled
      irq_after(80, 1'b0);
      rd("status", `SFT_ADDR_STATUS, 8'h2A);
      wr(`SFT_ADDR_QCTL1, 8'h03);
      irq_after(50, 1'b0);
      irq_after(40, 1'b1);
      rd("status", `SFT_ADDR_STATUS, 8'h6A);
      rd("data", `SFT_ADDR_DATA, 8'h44);
      wr(`SFT_ADDR_STATUS, 8'h00);
      irq_after(3, 1'b0);
      irq_after(90, 1'b0);
      rd("status", `SFT_ADDR_STATUS, 8'h23);
      wr(`SFT_ADDR_QCTL0, 8'hB2);
      irq_after(3, 1'b1);
      wr(`SFT_ADDR_QCTL0, 8'h32);
      irq_after(3, 1'b0);
   endtask

   initial begin
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_reset_vals();
      t_fill_collide();
      t_link();
      t_stall_discard();
      t_timeout();
      report_and_stop;
   end
endmodule
